/* File: hw/icr_pkg.sv */
// Constants for the interrupt clear block of the reference inputs and loops 0 and 1
package icr_pkg;

   // ---------------------------------------------------------------
   // Bus widths and register count
   // ---------------------------------------------------------------
   localparam int ICR_AW = 16;
   localparam int ICR_DW = 8;
   localparam int ICR_NREG = 8;

   // ---------------------------------------------------------------
   // Clearing register offsets (write only, read as zero)
   // ---------------------------------------------------------------
   localparam logic [15:0] REF_AB_CLR_OFS = 16'h0a07;
   localparam logic [15:0] REF_CD_CLR_OFS = 16'h0a08;
   localparam logic [15:0] L0_LOCK_CLR_OFS = 16'h0a09;
   localparam logic [15:0] L0_STATE_CLR_OFS = 16'h0a0a;
   localparam logic [15:0] L0_MISC_CLR_OFS = 16'h0a0b;
   localparam logic [15:0] L1_LOCK_CLR_OFS = 16'h0a0c;
   localparam logic [15:0] L1_STATE_CLR_OFS = 16'h0a0d;
   localparam logic [15:0] L1_MISC_CLR_OFS = 16'h0a0e;

   // ---------------------------------------------------------------
   // Pending flag images and activity registers (read side)
   // ---------------------------------------------------------------
   localparam logic [15:0] PEND_BASE_OFS = 16'h0c00;
   localparam logic [15:0] CLR_COUNT_OFS = 16'h0c10;
   localparam logic [15:0] CLR_LAST_OFS = 16'h0c11;

   // ---------------------------------------------------------------
   // Writable bit masks
   // ---------------------------------------------------------------
   localparam logic [7:0] REF_VALID_MASK = 8'h77;
   localparam logic [7:0] LOOP_VALID_MASK = 8'hff;

   // ---------------------------------------------------------------
   // Field positions shared by both reference registers
   // ---------------------------------------------------------------
   localparam int REF_LO_FAULT_BIT = 0;
   localparam int REF_LO_UNFAULT_BIT = 1;
   localparam int REF_LO_VALID_BIT = 2;
   localparam int REF_HI_FAULT_BIT = 4;
   localparam int REF_HI_UNFAULT_BIT = 5;
   localparam int REF_HI_VALID_BIT = 6;

   // ---------------------------------------------------------------
   // Reset values, count ceiling and no-write index
   // ---------------------------------------------------------------
   localparam logic [7:0] CLR_RST = 8'h00;
   localparam logic [7:0] PEND_RST = 8'h00;
   localparam logic [7:0] RD_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [3:0] LAST_RST = 4'h0;
   localparam logic [3:0] LAST_NONE = 4'hf;

endpackage

/* File: hw/icr_clear_lane.sv */
// One clearing register with its mirrored pending flags
`timescale 1ns/10ps
module icr_clear_lane
   import icr_pkg::*;
#(
   parameter logic [7:0] VALID_MASK = 8'hff
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Write side
   input wire logic wrHit,
   input wire logic [7:0] wrData,
   // Event side
   input wire logic [7:0] evt,
   output logic [7:0] clrPulse,
   output logic [7:0] pend
);

   typedef struct packed {
      logic [7:0] clr;
      logic [7:0] pend;
   } icr_lane_t;

   icr_lane_t st_q;
   icr_lane_t st_d;
   logic [7:0] clrNow;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      clrNow = wrHit ? (wrData & VALID_MASK) : CLR_RST;
      st_d = st_q;
      st_d.clr = clrNow;
      st_d.pend = (st_q.pend & ~clrNow) | evt;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q <= {CLR_RST, PEND_RST};
      end else begin
         st_q <= st_d;
      end
   end

   assign clrPulse = st_q.clr;
   assign pend = st_q.pend;

endmodule

/* File: hw/icr_irq_clear.sv */
// Interrupt clear registers for the reference inputs and digital loops 0 and 1
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps

// Behaviour
// - Ref clear A: bits 0..2 clear input A fault, fault-removed, validated.
// - Ref clear A: bits 4..6 clear input B fault, fault-removed, validated.
// - Ref clear B: bits 0..2 clear input C fault, fault-removed, validated.
// - Ref clear B: bits 4..6 clear input D fault, fault-removed, validated.
// - Loop 0 lock: bits 7..4 clear freq unclamp, clamp, slew unlimit, slew limit.
// - Loop 0 lock: bits 3..0 clear freq lost, freq lock, phase lost, phase lock.
// - Loop 0 state: bits 7..5 clear switching, free-run, holdover flags.
// - Loop 0 state: bit 4 clears tuning history updated flag.
// - Loop 0 state: bits 3..0 clear input D, C, B, A activated.
// - Loop 0 misc: bit 7 clears large phase step flag.
// - Loop 0 misc: bits 6,5 clear demap unclamp/clamp, bit 4 distribution sync.
// - Loop 0 misc: bits 3..0 clear analog loop unlock, lock, cal end, cal start.
// - Loop 1 lock: bits 7..4 clear freq unclamp, clamp, slew unlimit, slew limit.
// - Loop 1 lock: bits 3..0 clear freq lost, freq lock, phase lost, phase lock.
// - Loop 1 state: bits 7..4 clear switching, free-run, holdover, history.
// - Loop 1 state: bits 3..0 clear input D, C, B, A activated.
// - Loop 1 misc: bit 7 phase step, bits 6,5 demap unclamp/clamp.
// - Bit 4 of each loop misc register clears distribution sync flag.
// - Loop 1 misc: bits 3..0 clear analog loop unlock, lock, cal end, cal start.
// - A one in a clearing bit resets the matching pending flag unless that flag's event arrives in the same cycle.
// - Clearing bits return to zero by themselves after one cycle.
// - Clearing bit positions mirror the pending flag positions one for one.
module icr_irq_clear
   import icr_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Register port
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [7:0] regRdData,
   // Event pulses from the monitors
   input wire logic [7:0] refAbEvt,
   input wire logic [7:0] refCdEvt,
   input wire logic [7:0] loop0LockEvt,
   input wire logic [7:0] loop0StateEvt,
   input wire logic [7:0] loop0MiscEvt,
   input wire logic [7:0] loop1LockEvt,
   input wire logic [7:0] loop1StateEvt,
   input wire logic [7:0] loop1MiscEvt,
   // Clear pulses toward the monitor bank
   output logic [7:0] refAbClr,
   output logic [7:0] refCdClr,
   output logic [7:0] loop0LockClr,
   output logic [7:0] loop0StateClr,
   output logic [7:0] loop0MiscClr,
   output logic [7:0] loop1LockClr,
   output logic [7:0] loop1StateClr,
   output logic [7:0] loop1MiscClr,
   // Pending flag images
   output logic [7:0] refAbPend,
   output logic [7:0] refCdPend,
   output logic [7:0] loop0LockPend,
   output logic [7:0] loop0StatePend,
   output logic [7:0] loop0MiscPend,
   output logic [7:0] loop1LockPend,
   output logic [7:0] loop1StatePend,
   output logic [7:0] loop1MiscPend,
   // Summary
   output logic anyPend
);

   typedef struct packed {
      logic [7:0] rdData;
      logic anyPend;
      logic [7:0] clrCount;
      logic [3:0] lastClr;
   } icr_top_t;

   icr_top_t st_q;
   icr_top_t st_d;

   logic hitRefAb;
   logic hitRefCd;
   logic hitL0Lock;
   logic hitL0State;
   logic hitL0Misc;
   logic hitL1Lock;
   logic hitL1State;
   logic hitL1Misc;
   logic hitAny;
   logic [3:0] hitIdx;
   logic [7:0] pendNow;

   // ---------------------------------------------------------------
   // Write decode
   // ---------------------------------------------------------------
   assign hitRefAb = regWrStb && (regAddr == REF_AB_CLR_OFS);
   assign hitRefCd = regWrStb && (regAddr == REF_CD_CLR_OFS);
   assign hitL0Lock = regWrStb && (regAddr == L0_LOCK_CLR_OFS);
   assign hitL0State = regWrStb && (regAddr == L0_STATE_CLR_OFS);
   assign hitL0Misc = regWrStb && (regAddr == L0_MISC_CLR_OFS);
   assign hitL1Lock = regWrStb && (regAddr == L1_LOCK_CLR_OFS);
   assign hitL1State = regWrStb && (regAddr == L1_STATE_CLR_OFS);
   assign hitL1Misc = regWrStb && (regAddr == L1_MISC_CLR_OFS);

   assign hitAny = hitRefAb | hitRefCd | hitL0Lock | hitL0State | hitL0Misc
                 | hitL1Lock | hitL1State | hitL1Misc;

   // Register index of the write, used by the activity record
   always_comb begin
      hitIdx = LAST_NONE;
      if (hitRefAb) begin
         hitIdx = 4'h0;
      end else if (hitRefCd) begin
         hitIdx = 4'h1;
      end else if (hitL0Lock) begin
         hitIdx = 4'h2;
      end else if (hitL0State) begin
         hitIdx = 4'h3;
      end else if (hitL0Misc) begin
         hitIdx = 4'h4;
      end else if (hitL1Lock) begin
         hitIdx = 4'h5;
      end else if (hitL1State) begin
         hitIdx = 4'h6;
      end else if (hitL1Misc) begin
         hitIdx = 4'h7;
      end
   end

   // ---------------------------------------------------------------
   // Reference input lanes (bits 3 and 7 reserved)
   // ---------------------------------------------------------------
   icr_clear_lane #(
      .VALID_MASK(REF_VALID_MASK)
   ) u_ref_ab (
      .clock(clock),
      .sys_rst(sys_rst),
      .wrHit(hitRefAb),
      .wrData(regWrData),
      .evt(refAbEvt),
      .clrPulse(refAbClr),
      .pend(refAbPend)
   );

   icr_clear_lane #(
      .VALID_MASK(REF_VALID_MASK)
   ) u_ref_cd (
      .clock(clock),
      .sys_rst(sys_rst),
      .wrHit(hitRefCd),
      .wrData(regWrData),
      .evt(refCdEvt),
      .clrPulse(refCdClr),
      .pend(refCdPend)
   );

   // ---------------------------------------------------------------
   // Digital loop 0 lanes
   // ---------------------------------------------------------------
   icr_clear_lane #(
      .VALID_MASK(LOOP_VALID_MASK)
   ) u_l0_lock (
      .clock(clock),
      .sys_rst(sys_rst),
      .wrHit(hitL0Lock),
      .wrData(regWrData),
      .evt(loop0LockEvt),
      .clrPulse(loop0LockClr),
      .pend(loop0LockPend)
   );

   icr_clear_lane #(
      .VALID_MASK(LOOP_VALID_MASK)
   ) u_l0_state (
      .clock(clock),
      .sys_rst(sys_rst),
      .wrHit(hitL0State),
      .wrData(regWrData),
      .evt(loop0StateEvt),
      .clrPulse(loop0StateClr),
      .pend(loop0StatePend)
   );

   icr_clear_lane #(
      .VALID_MASK(LOOP_VALID_MASK)
   ) u_l0_misc (
      .clock(clock),
      .sys_rst(sys_rst),
      .wrHit(hitL0Misc),
      .wrData(regWrData),
      .evt(loop0MiscEvt),
      .clrPulse(loop0MiscClr),
      .pend(loop0MiscPend)
   );

   // ---------------------------------------------------------------
   // Digital loop 1 lanes
   // ---------------------------------------------------------------
   icr_clear_lane #(
      .VALID_MASK(LOOP_VALID_MASK)
   ) u_l1_lock (
      .clock(clock),
      .sys_rst(sys_rst),
      .wrHit(hitL1Lock),
      .wrData(regWrData),
      .evt(loop1LockEvt),
      .clrPulse(loop1LockClr),
      .pend(loop1LockPend)
   );

   icr_clear_lane #(
      .VALID_MASK(LOOP_VALID_MASK)
   ) u_l1_state (
      .clock(clock),
      .sys_rst(sys_rst),
      .wrHit(hitL1State),
      .wrData(regWrData),
      .evt(loop1StateEvt),
      .clrPulse(loop1StateClr),
      .pend(loop1StatePend)
   );

   icr_clear_lane #(
      .VALID_MASK(LOOP_VALID_MASK)
   ) u_l1_misc (
      .clock(clock),
      .sys_rst(sys_rst),
      .wrHit(hitL1Misc),
      .wrData(regWrData),
      .evt(loop1MiscEvt),
      .clrPulse(loop1MiscClr),
      .pend(loop1MiscPend)
   );

   assign pendNow = {|refAbPend, |refCdPend, |loop0LockPend, |loop0StatePend,
                     |loop0MiscPend, |loop1LockPend, |loop1StatePend, |loop1MiscPend};

   // ---------------------------------------------------------------
   // Read mux, activity record and summary
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.rdData = RD_RST;
      st_d.anyPend = |pendNow;
      if (regRdStb) begin
         // Clearing registers fall to the default and read as zero
         case (regAddr)
            PEND_BASE_OFS: begin
               st_d.rdData = refAbPend;
            end
            PEND_BASE_OFS + 16'h0001: begin
               st_d.rdData = refCdPend;
            end
            PEND_BASE_OFS + 16'h0002: begin
               st_d.rdData = loop0LockPend;
            end
            PEND_BASE_OFS + 16'h0003: begin
               st_d.rdData = loop0StatePend;
            end
            PEND_BASE_OFS + 16'h0004: begin
               st_d.rdData = loop0MiscPend;
            end
            PEND_BASE_OFS + 16'h0005: begin
               st_d.rdData = loop1LockPend;
            end
            PEND_BASE_OFS + 16'h0006: begin
               st_d.rdData = loop1StatePend;
            end
            PEND_BASE_OFS + 16'h0007: begin
               st_d.rdData = loop1MiscPend;
            end
            CLR_COUNT_OFS: begin
               st_d.rdData = st_q.clrCount;
            end
            CLR_LAST_OFS: begin
               st_d.rdData = {4'h0, st_q.lastClr};
            end
            default: begin
               st_d.rdData = RD_RST;
            end
         endcase
      end
      if (regWrStb && (regAddr == CLR_COUNT_OFS)) begin
         st_d.clrCount = COUNT_RST;
      end else if (hitAny && (st_q.clrCount != COUNT_MAX)) begin
         st_d.clrCount = st_q.clrCount + 8'h01;
      end
      if (hitAny) begin
         st_d.lastClr = hitIdx;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q <= {RD_RST, 1'b0, COUNT_RST, LAST_RST};
      end else begin
         st_q <= st_d;
      end
   end

   assign regRdData = st_q.rdData;
   assign anyPend = st_q.anyPend;

endmodule

/* File: bench/icr_irq_clear_sva.sv */
// Port assertions for the interrupt clear block
`timescale 1ns/10ps
module icr_irq_clear_sva
   import icr_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Register port
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [7:0] regRdData,
   // Events
   input wire logic [7:0] refAbEvt,
   input wire logic [7:0] refCdEvt,
   input wire logic [7:0] loop0LockEvt,
   input wire logic [7:0] loop0StateEvt,
   input wire logic [7:0] loop0MiscEvt,
   input wire logic [7:0] loop1LockEvt,
   input wire logic [7:0] loop1StateEvt,
   input wire logic [7:0] loop1MiscEvt,
   // Clears
   input wire logic [7:0] refAbClr,
   input wire logic [7:0] refCdClr,
   input wire logic [7:0] loop0LockClr,
   input wire logic [7:0] loop0StateClr,
   input wire logic [7:0] loop0MiscClr,
   input wire logic [7:0] loop1LockClr,
   input wire logic [7:0] loop1StateClr,
   input wire logic [7:0] loop1MiscClr,
   // Pending
   input wire logic [7:0] refAbPend,
   input wire logic [7:0] refCdPend,
   input wire logic [7:0] loop0LockPend,
   input wire logic [7:0] loop0StatePend,
   input wire logic [7:0] loop0MiscPend,
   input wire logic [7:0] loop1LockPend,
   input wire logic [7:0] loop1StatePend,
   input wire logic [7:0] loop1MiscPend,
   input wire logic anyPend
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   logic [63:0] evtAll, clrAll, pendAll, expClr;
   logic rstDly_q;
   assign evtAll = {loop1MiscEvt, loop1StateEvt, loop1LockEvt, loop0MiscEvt, loop0StateEvt, loop0LockEvt, refCdEvt,
      refAbEvt};
   assign clrAll = {loop1MiscClr, loop1StateClr, loop1LockClr, loop0MiscClr, loop0StateClr, loop0LockClr, refCdClr,
      refAbClr};
   assign pendAll = {loop1MiscPend, loop1StatePend, loop1LockPend, loop0MiscPend, loop0StatePend, loop0LockPend,
      refCdPend, refAbPend};
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         expClr[i*8 +: 8] = (regWrStb && regAddr == REF_AB_CLR_OFS + 16'(i)) ?
            regWrData & (i < 2 ? REF_VALID_MASK : LOOP_VALID_MASK) : 8'h00;
      end
   end
   // First edge after reset still sees values from the reset cycle
   always_ff @(posedge clock) rstDly_q <= sys_rst;
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst || rstDly_q);
   ref_clear_a: assert property (regWrStb |=> clrAll[15:0] == $past(expClr[15:0]))
      else $error("reference clear pulses wrong");
   loop0_clear_a: assert property (regWrStb |=> clrAll[39:16] == $past(expClr[39:16]))
      else $error("loop 0 clear pulses wrong");
   loop1_clear_a: assert property (regWrStb |=> clrAll[63:40] == $past(expClr[63:40]))
      else $error("loop 1 clear pulses wrong");
   clear_self_a: assert property (!regWrStb |=> clrAll == 64'h0)
      else $error("clear pulse without write");
   pend_update_a: assert property (pendAll == (($past(pendAll) & ~clrAll) | $past(evtAll)))
      else $error("pending flags updated wrongly");
   any_pend_a: assert property (anyPend == $past(|pendAll))
      else $error("summary flag wrong");
   rd_pend_a: assert property (regRdStb && regAddr[15:3] == PEND_BASE_OFS[15:3] |=>
      regRdData == $past(pendAll[regAddr[2:0]*8 +: 8]))
      else $error("pending image read wrong");
   rd_clear_zero_a: assert property (regRdStb && regAddr inside {[REF_AB_CLR_OFS:L1_MISC_CLR_OFS]} |=> regRdData == 8'h00)
      else $error("clearing register read not zero");
   rd_idle_a: assert property (!regRdStb |=> regRdData == 8'h00)
      else $error("read data outside read cycle");
   cover property (regWrStb && |expClr);
   cover property (|($past(evtAll) & clrAll));
   cover property (regRdStb && regAddr == CLR_COUNT_OFS);
endmodule

/* File: bench/icr_irq_clear_bench.sv */
// Self-checking bench for the interrupt clear block
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch at %0t got %h expected %h", $time, (g), (e)); end end
module icr_irq_clear_bench
   import icr_pkg::*;
;
   logic clock = 1'b0, sys_rst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0, anyPend, rdDly = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [7:0] regWrData = 8'h00, regRdData, rdExp, mCount = COUNT_RST;
   logic [7:0] evt [8] = '{default: 8'h00};
   logic [7:0] mPend [8] = '{default: 8'h00};
   logic [7:0] clr [8], pend [8], rdQ [$];
   logic [63:0] ex, clrQ [$];
   logic [3:0] mLast = LAST_RST;
   int n_fail = 0, compares = 0, cycles = 0;
   wire [63:0] cl = {clr[7], clr[6], clr[5], clr[4], clr[3], clr[2], clr[1], clr[0]};
   always #4 clock = ~clock;
   icr_irq_clear DUT (.clock, .sys_rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
      .refAbEvt(evt[0]), .refCdEvt(evt[1]), .loop0LockEvt(evt[2]), .loop0StateEvt(evt[3]),
      .loop0MiscEvt(evt[4]), .loop1LockEvt(evt[5]), .loop1StateEvt(evt[6]), .loop1MiscEvt(evt[7]),
      .refAbClr(clr[0]), .refCdClr(clr[1]), .loop0LockClr(clr[2]), .loop0StateClr(clr[3]),
      .loop0MiscClr(clr[4]), .loop1LockClr(clr[5]), .loop1StateClr(clr[6]), .loop1MiscClr(clr[7]),
      .refAbPend(pend[0]), .refCdPend(pend[1]), .loop0LockPend(pend[2]), .loop0StatePend(pend[3]),
      .loop0MiscPend(pend[4]), .loop1LockPend(pend[5]), .loop1StatePend(pend[6]), .loop1MiscPend(pend[7]),
      .anyPend);
   // ---------------------------------------------------------------
   // Driver with reference model: one bus cycle and one event lane
   // ---------------------------------------------------------------
   task automatic op(logic w, r, logic [15:0] a, logic [7:0] d, int ln, logic [7:0] ev);
      logic [63:0] c;
      int k;
      c = 64'h0;
      k = int'(a) - int'(REF_AB_CLR_OFS);
      ev = ln < 2 ? ev & REF_VALID_MASK : ev;
      @(posedge clock);
      regWrStb <= w;
      regRdStb <= r;
      regAddr <= a;
      regWrData <= d;
      for (int i = 0; i < 8; i++) evt[i] <= (i == ln) ? ev : 8'h00;
      if (r) rdQ.push_back(a == CLR_COUNT_OFS ? mCount : a == CLR_LAST_OFS ? {4'h0, mLast} :
         a[15:3] == PEND_BASE_OFS[15:3] ? mPend[a[2:0]] : 8'h00);
      if (w && k >= 0 && k < 8) begin
         c[k*8 +: 8] = d & (k < 2 ? REF_VALID_MASK : LOOP_VALID_MASK);
         mPend[k] = mPend[k] & ~c[k*8 +: 8];
         mCount = mCount == COUNT_MAX ? mCount : mCount + 8'h01;
         mLast = 4'(k);
         if (|c) clrQ.push_back(c);
      end
      if (w && a == CLR_COUNT_OFS) mCount = COUNT_RST;
      if (ln >= 0) mPend[ln] = mPend[ln] | ev;
   endtask
   task automatic idle(int n);
      repeat (n) op(1'b0, 1'b0, 16'h0000, 8'h00, -1, 8'h00);
   endtask
   task automatic rdAll();
      for (int i = 0; i < 8; i++) op(1'b0, 1'b1, PEND_BASE_OFS + 16'(i), 8'h00, -1, 8'h00);
      op(1'b0, 1'b1, CLR_COUNT_OFS, 8'h00, -1, 8'h00);
      op(1'b0, 1'b1, CLR_LAST_OFS, 8'h00, -1, 8'h00);
      idle(2);
      // Traffic is quiet here, so the flag images and the summary have settled
      for (int i = 0; i < 8; i++) `CHK(pend[i], mPend[i])
      `CHK(anyPend, |{mPend[7], mPend[6], mPend[5], mPend[4], mPend[3], mPend[2], mPend[1], mPend[0]})
   endtask
   task automatic summarize();
      `CHK(clrQ.size() + rdQ.size(), 0)
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Monitor and timeout
   // ---------------------------------------------------------------
   always @(posedge clock) begin
      if (rdDly) begin
         rdExp = rdQ.pop_front();
         `CHK(regRdData, rdExp)
      end
      if (|cl) begin
         ex = clrQ.pop_front();
         `CHK(cl[15:0], ex[15:0])
         `CHK(cl[39:16], ex[39:16])
         `CHK(cl[63:40], ex[63:40])
      end
      rdDly <= regRdStb;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      int l;
      logic [15:0] pa;
      void'($urandom(32'h8a9c));
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++) `CHK(pend[i], PEND_RST)
      rdAll();
      op(1'b0, 1'b1, 16'h0bff, 8'h00, -1, 8'h00);
      op(1'b0, 1'b1, REF_AB_CLR_OFS, 8'h00, -1, 8'h00);
      idle(2);
      $display("test reset done");
      for (int ln = 0; ln < 8; ln++) begin
         pa = REF_AB_CLR_OFS + 16'(ln);
         op(1'b0, 1'b0, 16'h0000, 8'h00, ln, 8'hff);
         op(1'b1, 1'b0, pa, 8'h88, -1, 8'h00);
         op(1'b1, 1'b0, pa, 8'h00, -1, 8'h00);
         for (int b = 0; b < 8; b++) begin
            op(1'b1, 1'b0, pa, 8'h01 << b, -1, 8'h00);
            op(1'b0, 1'b1, PEND_BASE_OFS + 16'(ln), 8'h00, -1, 8'h00);
         end
      end
      op(1'b1, 1'b0, L0_MISC_CLR_OFS, 8'hff, 4, 8'h10);
      rdAll();
      $display("test bit walk done");
      for (int i = 0; i < 400; i++) begin
         l = $urandom_range(7);
         if ($urandom_range(3) == 0) op(1'b0, 1'b1, PEND_BASE_OFS + 16'(l), 8'h00, $urandom_range(7), 8'($urandom));
         else op(1'b1, 1'b0, REF_AB_CLR_OFS + 16'(l), 8'($urandom), $urandom_range(7), 8'($urandom));
      end
      rdAll();
      op(1'b1, 1'b0, 16'h0a15, 8'hff, -1, 8'h00);
      op(1'b1, 1'b0, PEND_BASE_OFS, 8'hff, -1, 8'h00);
      op(1'b1, 1'b0, CLR_COUNT_OFS, 8'h00, -1, 8'h00);
      rdAll();
      $display("test random traffic done");
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      foreach (mPend[i]) mPend[i] = PEND_RST;
      mCount = COUNT_RST;
      mLast = LAST_RST;
      rdAll();
      $display("test mid-run reset done");
      // Let the monitor take the last read before the queues are judged
      repeat (2) @(posedge clock);
      summarize();
   end
endmodule
bind icr_irq_clear icr_irq_clear_sva chk (.clock, .sys_rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
   .refAbEvt, .refCdEvt, .loop0LockEvt, .loop0StateEvt, .loop0MiscEvt, .loop1LockEvt, .loop1StateEvt, .loop1MiscEvt,
   .refAbClr, .refCdClr, .loop0LockClr, .loop0StateClr, .loop0MiscClr, .loop1LockClr, .loop1StateClr, .loop1MiscClr,
   .refAbPend, .refCdPend, .loop0LockPend, .loop0StatePend, .loop0MiscPend, .loop1LockPend, .loop1StatePend,
   .loop1MiscPend, .anyPend);
